// ---- hw/flash_protect_pkg.sv ----
// Shared constants for the flash write-protection logic: opcodes, status layout,
// protect-level decoding figures and state encoding.
// Assumes a 25-bit byte address into a 32 MB array and an 8-bit status register.
`default_nettype none

package flash_protect_pkg;

  // Widths
  localparam int ADDR_WIDTH = 25;
  localparam int DATA_WIDTH = 8;

  // Command opcodes seen by this block
  localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OPC_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OPC_SET_READ_PARAMS_VOL = 8'hC0;
  localparam logic [7:0] OPC_WRITE_BANK_VOL = 8'h17;
  localparam logic [7:0] OPC_CHIP_ERASE_A = 8'hC7;
  localparam logic [7:0] OPC_CHIP_ERASE_B = 8'h60;

  // Program and erase opcodes that target an address
  localparam int ARRAY_OPC_COUNT = 13;
  localparam logic [7:0] ARRAY_OPCODES [ARRAY_OPC_COUNT] = '{
    8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3E, 8'hD7,
    8'h20, 8'h21, 8'h52, 8'h5C, 8'hD8, 8'hDC
  };

  // Status register layout
  localparam int SR_WIP_BIT = 0;
  localparam int SR_WEL_BIT = 1;
  localparam int SR_LEVEL_LSB = 2;
  localparam int SR_LEVEL_MSB = 5;
  localparam int SR_QUAD_BIT = 6;
  localparam int SR_SWD_BIT = 7;
  localparam logic [7:0] SR_NV_MASK = 8'hFC;
  localparam logic [7:0] SR_RESET_VALUE = 8'h00;

  // Block geometry
  localparam int BLOCK_64K_LSB = 16;
  localparam int BLOCK_256K_LSB = 18;
  localparam logic [9:0] BLOCKS_64K = 10'h200;
  localparam logic [9:0] BLOCKS_256K = 10'h080;

  // Protect level figures
  localparam logic [3:0] LEVEL_NONE = 4'h0;
  localparam logic [3:0] LEVEL_ONE = 4'h1;
  localparam logic [3:0] LEVEL_LAST_DOUBLING = 4'h9;
  localparam logic [3:0] LEVEL_ALL = 4'hF;
  localparam logic [4:0] TAIL_SHIFT_BASE = 5'h11;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_STATUS_WRITE,
    ST_ARRAY_BUSY
  } ctrl_state_type;

endpackage

`default_nettype wire

// ---- hw/protect_range_decode.sv ----
// Decodes a protect level and top/bottom choice into a hit flag for one address.
// Assumes the level, selection and block-size option are stable while decoding.
`default_nettype none

module protect_range_decode (
  input wire logic [3:0] level_in,
  input wire logic top_bottom_in,
  input wire logic block_256k_in,
  input wire logic [flash_protect_pkg::ADDR_WIDTH-1:0] addr_in,
  output logic hit_out
);
  import flash_protect_pkg::*;

  // Counts of protected blocks for each geometry
  wire [9:0] doubling = 10'h001 << (level_in - LEVEL_ONE);
  wire [4:0] tail_shift = TAIL_SHIFT_BASE - {1'b0, level_in};
  wire [9:0] tail_count = BLOCKS_64K - (10'h001 << tail_shift);
  wire [9:0] count_64k = (level_in == LEVEL_NONE) ? 10'h000 :
                         (level_in <= LEVEL_LAST_DOUBLING) ? doubling :
                         (level_in == LEVEL_ALL) ? BLOCKS_64K : tail_count;
  wire [9:0] count_256k = level_in[3] ? BLOCKS_256K :
                          (level_in == LEVEL_NONE) ? 10'h000 : doubling;

  // Geometry selection; the 256 KB index simply drops two address bits
  wire [9:0] count = block_256k_in ? count_256k : count_64k;
  wire [9:0] total = block_256k_in ? BLOCKS_256K : BLOCKS_64K;
  wire [9:0] index = block_256k_in ? {3'b000, addr_in[ADDR_WIDTH-1:BLOCK_256K_LSB]}
                                   : {1'b0, addr_in[ADDR_WIDTH-1:BLOCK_64K_LSB]};

  // Top range ends at the last block, bottom range starts at block zero
  wire [9:0] index_plus = index + count;
  wire top_hit = index_plus >= total;
  wire bottom_hit = index < count;

  assign hit_out = (count != 10'h000) && (top_bottom_in ? bottom_hit : top_hit);

endmodule

`default_nettype wire

// ---- hw/flash_block_write_protect.sv ----
// Write-protection decision logic of a serial flash: status register, write
// enable latch, block-protect check, chip-erase guard and WP/HOLD pin roles.
// Assumes commands arrive already decoded, one per cmd_valid_in pulse, and that
// an external non-volatile cell stores the status bits across power cycles.
`default_nettype none

// Function
// - The volatile read-parameter command C0h and volatile bank command 17h are accepted with the latch clear.
// - A program or erase whose target lies inside the protected region is inhibited.
// - Chip erase is ignored unless all four protect-level bits are zero.
// - With the status write disable bit at zero the status register stays writable whatever the WP pin does.
// - With that bit at one, quad enable at zero and WP low, a status write is ignored and its bits stay read-only.
// - With that bit at one and WP high, a status write still changes the register.
// - With quad enable at zero the WP and HOLD/RESET pins keep their control roles.
// - With quad enable at one those two pins serve as data lines IO2 and IO3.
// - Quad enable, the status write disable bit and the four protect-level bits are kept non-volatile and reloaded at reset.
// - With 64 KB blocks levels protect none, 1 doubling to 256, then 384 to 504, and all 512 at level 15.
// - Top selection places the range so that it ends at the highest block.
// - Bottom selection places the range so that it starts at block zero.
// - With 256 KB blocks levels 1 to 7 protect 1 to 64 blocks and any level with the top bit protects all.
module flash_block_write_protect (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_opcode_in,
  input wire logic [flash_protect_pkg::ADDR_WIDTH-1:0] cmd_addr_in,
  input wire logic [flash_protect_pkg::DATA_WIDTH-1:0] cmd_data_in,
  input wire logic write_protect_n_in,
  input wire logic hold_reset_n_in,
  input wire logic top_bottom_select_in,
  input wire logic block_256k_in,
  input wire logic [flash_protect_pkg::DATA_WIDTH-1:0] nv_status_in,
  input wire logic nv_write_done_in,
  input wire logic array_done_in,
  output logic [flash_protect_pkg::DATA_WIDTH-1:0] status_out,
  output logic array_start_out,
  output logic [7:0] array_opcode_out,
  output logic [flash_protect_pkg::ADDR_WIDTH-1:0] array_addr_out,
  output logic op_inhibited_out,
  output logic cmd_ignored_out,
  output logic volatile_cmd_out,
  output logic [7:0] volatile_opcode_out,
  output logic nv_write_out,
  output logic [flash_protect_pkg::DATA_WIDTH-1:0] nv_status_out,
  output logic quad_enable_out,
  output logic wp_function_out,
  output logic hold_function_out,
  output logic hold_asserted_out,
  output logic status_locked_out
);
  import flash_protect_pkg::*;

  ctrl_state_type state_q;
  ctrl_state_type state_d;
  logic [DATA_WIDTH-1:0] status_q;
  logic [DATA_WIDTH-1:0] status_d;
  logic range_hit;

  // Opcode classification
  wire [ARRAY_OPC_COUNT-1:0] array_match;
  genvar gi;
  generate
    for (gi = 0; gi < ARRAY_OPC_COUNT; gi++) begin : g_array_opc
      assign array_match[gi] = (cmd_opcode_in == ARRAY_OPCODES[gi]);
    end
  endgenerate

  wire is_array_op = |array_match;
  wire is_write_enable_cmd = (cmd_opcode_in == OPC_WRITE_ENABLE);
  wire is_write_disable_cmd = (cmd_opcode_in == OPC_WRITE_DISABLE);
  wire is_write_status_cmd = (cmd_opcode_in == OPC_WRITE_STATUS);
  wire is_chip_erase = (cmd_opcode_in == OPC_CHIP_ERASE_A) || (cmd_opcode_in == OPC_CHIP_ERASE_B);

  // Volatile pair; these skip the latch, so they never count as write types
  wire is_volatile = (cmd_opcode_in == OPC_SET_READ_PARAMS_VOL) || (cmd_opcode_in == OPC_WRITE_BANK_VOL);

  // Commands that need the latch and report a refusal when not acted on
  wire is_write_type = is_write_status_cmd || is_array_op || is_chip_erase;

  // Current status fields
  wire latch_set = status_q[SR_WEL_BIT];
  wire [3:0] protect_level = status_q[SR_LEVEL_MSB:SR_LEVEL_LSB];
  wire quad_enable = status_q[SR_QUAD_BIT];
  wire status_write_disable = status_q[SR_SWD_BIT];
  wire level_zero = (protect_level == LEVEL_NONE);

  // Only an idle device acts on commands; a busy one ignores them all
  wire idle = (state_q == ST_IDLE);
  wire accept = cmd_valid_in && idle;

  // Hardware protection; with quad enable set the WP pin is a data line and cannot lock
  wire wp_pin_low = !quad_enable && !write_protect_n_in;
  wire status_locked = status_write_disable && wp_pin_low;

  // Address check of the target against the protected range
  protect_range_decode u_range (
    .level_in(protect_level),
    .top_bottom_in(top_bottom_select_in),
    .block_256k_in(block_256k_in),
    .addr_in(cmd_addr_in),
    .hit_out(range_hit)
  );

  // Go decisions; each write type needs the latch except the volatile pair
  wire status_write_go = accept && is_write_status_cmd && latch_set && !status_locked;
  wire array_go = accept && is_array_op && latch_set && !range_hit;
  wire chip_go = accept && is_chip_erase && latch_set && level_zero;
  wire volatile_go = accept && is_volatile;
  wire start_go = array_go || chip_go;

  // Protection refusals, reported separately from plain ignores
  wire range_block = is_array_op && range_hit;
  wire chip_block = is_chip_erase && !level_zero;
  wire inhibit = accept && latch_set && (range_block || chip_block);

  // Any command while busy, or a write type refused for missing latch, locked status or protected target
  wire write_refused = accept && is_write_type && !(status_write_go || start_go);
  wire ignored = (cmd_valid_in && !idle) || write_refused;

  // Status register write value; the latch and busy bits are never written this way
  wire [DATA_WIDTH-1:0] status_write_value = (cmd_data_in & SR_NV_MASK) | (status_q & ~SR_NV_MASK);

  // Completion events; each ends the busy period and drops the latch in the same update
  wire status_write_done = (state_q == ST_STATUS_WRITE) && nv_write_done_in;
  wire array_op_done = (state_q == ST_ARRAY_BUSY) && array_done_in;
  wire op_done = status_write_done || array_op_done;

  // Next status: unlocked writes pass regardless of WP when the disable bit is clear
  always_comb begin
    status_d = status_q;
    if (status_write_go) begin
      status_d = status_write_value;
    end
    if (accept && is_write_disable_cmd) begin
      status_d[SR_WEL_BIT] = 1'b0;
    end
    if (op_done) begin
      status_d[SR_WEL_BIT] = 1'b0;
    end
    if (accept && is_write_enable_cmd) begin
      status_d[SR_WEL_BIT] = 1'b1;
    end
    status_d[SR_WIP_BIT] = 1'b0;
  end

  // Control sequence: a status write waits for the cell, an array op for the engine
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (status_write_go) begin
          state_d = ST_STATUS_WRITE;
        end else if (start_go) begin
          state_d = ST_ARRAY_BUSY;
        end
      end
      ST_STATUS_WRITE: begin
        if (nv_write_done_in) begin
          state_d = ST_IDLE;
        end
      end
      ST_ARRAY_BUSY: begin
        if (array_done_in) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Busy flag shown in status follows the next state so reads see it at once
  wire busy_d = (state_d != ST_IDLE);
  wire [DATA_WIDTH-1:0] status_view_d = {status_d[DATA_WIDTH-1:1], busy_d};

  // Pin roles from the next quad enable value, so outputs track status writes
  wire quad_d = status_d[SR_QUAD_BIT];
  wire locked_d = status_d[SR_SWD_BIT] && !quad_d && !write_protect_n_in;
  wire hold_d = !quad_d && !hold_reset_n_in;

  // Control state
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Status bits; reset reloads the kept bits from the non-volatile cell
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      status_q <= (nv_status_in & SR_NV_MASK) | SR_RESET_VALUE;
    end else begin
      status_q <= status_d;
    end
  end

  // Cell update request; the new value is written back so it survives power loss
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      nv_write_out <= 1'b0;
      nv_status_out <= SR_RESET_VALUE;
    end else begin
      nv_write_out <= status_write_go;
      if (status_write_go) begin
        nv_status_out <= status_write_value & SR_NV_MASK;
      end
    end
  end

  // Array engine start pulse; one cycle per accepted launch
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      array_start_out <= 1'b0;
    end else begin
      array_start_out <= start_go;
    end
  end

  // Launch opcode and address held for the engine until the next start
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      array_opcode_out <= 8'h00;
      array_addr_out <= '0;
    end else if (start_go) begin
      array_opcode_out <= cmd_opcode_in;
      array_addr_out <= cmd_addr_in;
    end
  end

  // Volatile commands are handed on without touching the latch
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      volatile_cmd_out <= 1'b0;
    end else begin
      volatile_cmd_out <= volatile_go;
    end
  end

  // Last volatile opcode, held so the parameter logic can pick it up late
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      volatile_opcode_out <= 8'h00;
    end else if (volatile_go) begin
      volatile_opcode_out <= cmd_opcode_in;
    end
  end

  // Protection refusal pulse, only when the latch would otherwise have allowed it
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      op_inhibited_out <= 1'b0;
    end else begin
      op_inhibited_out <= inhibit;
    end
  end

  // Ignore pulse; busy, missing latch, lock and protection all look alike here
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cmd_ignored_out <= 1'b0;
    end else begin
      cmd_ignored_out <= ignored;
    end
  end

  // Status view; registered so the host never sees a half-updated byte
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      status_out <= SR_RESET_VALUE;
    end else begin
      status_out <= status_view_d;
    end
  end

  // Pin roles; quad mode frees both pins as data lines
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      quad_enable_out <= 1'b0;
      wp_function_out <= 1'b0;
      hold_function_out <= 1'b0;
    end else begin
      quad_enable_out <= quad_d;
      wp_function_out <= !quad_d;
      hold_function_out <= !quad_d;
    end
  end

  // Pin-derived levels; both read the raw pins, so they lag them by one edge
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      hold_asserted_out <= 1'b0;
      status_locked_out <= 1'b0;
    end else begin
      hold_asserted_out <= hold_d;
      status_locked_out <= locked_d;
    end
  end

endmodule

`default_nettype wire

// ---- bench/flash_protect_sva.sv ----
// Checker for the write-protection block, bound to its ports.
// Assumes one clock and the block's synchronous active-high reset.
`default_nettype none
module flash_protect_sva
  import flash_protect_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_opcode_in,
  input wire logic [7:0] cmd_data_in,
  input wire logic write_protect_n_in,
  input wire logic [7:0] nv_status_in,
  input wire logic [7:0] status_out,
  input wire logic array_start_out,
  input wire logic op_inhibited_out,
  input wire logic cmd_ignored_out,
  input wire logic volatile_cmd_out,
  input wire logic [7:0] volatile_opcode_out,
  input wire logic nv_write_out,
  input wire logic [7:0] nv_status_out,
  input wire logic quad_enable_out,
  input wire logic wp_function_out,
  input wire logic hold_function_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // Command taken while idle, split by kind; latch taken from the status byte
  wire logic go = cmd_valid_in && !status_out[0];
  wire logic wsr = go && status_out[1] && cmd_opcode_in == OPC_WRITE_STATUS;
  wire logic prog = go && status_out[1] && (cmd_opcode_in inside {ARRAY_OPCODES});
  wire logic ce = go && status_out[1] && (cmd_opcode_in inside {OPC_CHIP_ERASE_A, OPC_CHIP_ERASE_B});
  wire logic lvl_zero = status_out[5:2] == LEVEL_NONE;

  vol_accept_a: assert property (
    go && (cmd_opcode_in inside {8'hC0, 8'h17}) |=> volatile_cmd_out && volatile_opcode_out == $past(cmd_opcode_in))
    else $error("volatile command not accepted");
  no_level_a: assert property (
    prog && lvl_zero |=> array_start_out && !op_inhibited_out) else $error("unprotected program refused");
  full_level_a: assert property (
    prog && status_out[5:2] == LEVEL_ALL |=> op_inhibited_out && !array_start_out) else $error("full level let write in");
  erase_guard_a: assert property (
    ce |=> array_start_out == $past(lvl_zero)) else $error("chip erase guard wrong");
  open_write_a: assert property (
    wsr && !status_out[7] |=> nv_write_out && nv_status_out == ($past(cmd_data_in) & SR_NV_MASK))
    else $error("open status write not stored");
  locked_write_a: assert property (
    wsr && status_out[7] && !status_out[6] && !write_protect_n_in |=> cmd_ignored_out && !nv_write_out)
    else $error("locked status written");
  pin_high_write_a: assert property (
    wsr && status_out[7] && write_protect_n_in |=> nv_write_out) else $error("status write with pin high refused");
  pin_roles_a: assert property (
    !$past(rst_in) |-> wp_function_out != quad_enable_out && hold_function_out != quad_enable_out)
    else $error("pin roles disagree with quad enable");
  reload_a: assert property (
    $past(rst_in, 2) && !$past(rst_in) |-> status_out == ($past(nv_status_in, 2) & SR_NV_MASK))
    else $error("status not reloaded at reset");
  inhibit_quiet_a: assert property (
    op_inhibited_out |-> !array_start_out && !status_out[0] && status_out[1]) else $error("inhibit started a cycle");
  // Main scenarios reached
  cover property (array_start_out);
  cover property (op_inhibited_out);
  cover property (nv_write_out && status_out[7]);
endmodule
`default_nettype wire

// ---- bench/flash_engine_model.sv ----
// Model of the non-volatile status cell and the program/erase engine.
// Assumes launch pulses from the block; answers after a latency set by the bench.
`default_nettype none
module flash_engine_model #(
  parameter logic [7:0] INIT_STATUS = 8'h00
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic nv_write_in,
  input wire logic array_start_in,
  input wire logic [7:0] nv_status_in,
  input wire logic [3:0] latency_in,
  output logic [7:0] nv_status_out,
  output logic nv_write_done_out,
  output logic array_done_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy_q = 1'b0;
  logic kind_q = 1'b0;
  logic [3:0] count_q = 4'h0;
  // Stored byte survives the block's reset, as a real cell would
  initial nv_status_out = INIT_STATUS;
  initial nv_write_done_out = 1'b0;
  initial array_done_out = 1'b0;
  // One job at a time; zero latency still answers a cycle later
  always @(posedge mclk_in) begin
    nv_write_done_out <= 1'b0;
    array_done_out <= 1'b0;
    if (rst_in) begin
      busy_q <= 1'b0;
    end else if (nv_write_in || array_start_in) begin
      busy_q <= 1'b1;
      kind_q <= nv_write_in;
      count_q <= latency_in;
      if (nv_write_in) nv_status_out <= nv_status_in;
    end else if (busy_q) begin
      if (count_q == 4'h0) begin
        busy_q <= 1'b0;
        nv_write_done_out <= kind_q;
        array_done_out <= !kind_q;
      end else begin
        count_q <= count_q - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the write-protection block with a cell and engine model.
// Assumes decoded commands, one per valid pulse, on the block's command port.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_protect_pkg::*;
  logic mclk_in = 0, rst_in = 1, cmd_valid_in = 0, wp_n = 0, hold_n = 1, top_bottom_select = 0, big = 0;
  logic [7:0] cmd_opcode_in = 8'h00, cmd_data_in = 8'h00, nv_in, status_out, arr_op, vol_op, nv_out;
  logic [24:0] cmd_addr_in = 25'h0000000, arr_addr;
  logic arr_start, inhibited, ignored, vol, nv_write, nv_done, arr_done, quad, wp_fn, hold_fn, hold_on, locked;
  logic [3:0] lat = 4'h1;
  int n_errors = 0, checks_done = 0;
  flash_block_write_protect u_dut (.mclk_in(mclk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in),
    .cmd_opcode_in(cmd_opcode_in), .cmd_addr_in(cmd_addr_in), .cmd_data_in(cmd_data_in),
    .write_protect_n_in(wp_n), .hold_reset_n_in(hold_n), .top_bottom_select_in(top_bottom_select),
    .block_256k_in(big),
    .nv_status_in(nv_in), .nv_write_done_in(nv_done), .array_done_in(arr_done), .status_out(status_out),
    .array_start_out(arr_start), .array_opcode_out(arr_op), .array_addr_out(arr_addr),
    .op_inhibited_out(inhibited), .cmd_ignored_out(ignored), .volatile_cmd_out(vol),
    .volatile_opcode_out(vol_op), .nv_write_out(nv_write), .nv_status_out(nv_out), .quad_enable_out(quad),
    .wp_function_out(wp_fn), .hold_function_out(hold_fn), .hold_asserted_out(hold_on), .status_locked_out(locked));
  flash_engine_model u_model (.mclk_in(mclk_in), .rst_in(rst_in), .nv_write_in(nv_write),
    .array_start_in(arr_start), .nv_status_in(nv_out), .latency_in(lat), .nv_status_out(nv_in),
    .nv_write_done_out(nv_done), .array_done_out(arr_done));
  initial begin
    forever #20 mclk_in = ~mclk_in;
  end
  task automatic end_of_test();
    $display("errors %0d, checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One command per call; its result pulses are visible when the call returns
  task automatic cmd(input logic [7:0] op, input logic [24:0] addr, input logic [7:0] data);
    @(posedge mclk_in) #1;
    cmd_valid_in = 1'b1;
    cmd_opcode_in = op;
    cmd_addr_in = addr;
    cmd_data_in = data;
    @(posedge mclk_in) #1;
    cmd_valid_in = 1'b0;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (status_out[0] !== 1'b0 && n < 40) begin
      @(posedge mclk_in) #1;
      n++;
    end
    chk(n < 40, 1);
  endtask
  task automatic wsr(input logic [7:0] d);
    cmd(8'h06, '0, '0);
    cmd(8'h01, '0, d);
    chk(nv_write, 1);
    chk(nv_out, d & SR_NV_MASK);
  endtask
  // Launch at one block; a protected one must be refused and leave no start
  task automatic prog(input int blk, input bit prot, input logic [7:0] opc);
    logic [24:0] a;
    a = (big ? 25'(blk) << 18 : 25'(blk) << 16) | 25'h000ABCD;
    cmd(8'h06, '0, '0);
    cmd(opc, a, '0);
    chk(arr_start, !prot);
    chk(inhibited, prot);
    if (prot) cmd(8'h04, '0, '0);
    else begin
      chk(arr_addr, a);
      chk(arr_op, opc);
      wait_idle();
    end
  endtask
  // Blocks protected per level, worked out from the level tables
  function automatic int nblk(input int l, input bit b);
    if (b) return l == 0 ? 0 : l < 8 ? 1 << (l - 1) : 128;
    return l == 0 ? 0 : l < 10 ? 1 << (l - 1) : l == 15 ? 512 : 512 - (1 << (17 - l));
  endfunction
  initial begin
    #1_000_000;
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge mclk_in);
    #1 rst_in = 1'b0;
    // Every level, both placements, both block sizes: edge blocks inside and outside
    for (int b = 0; b < 2; b++) begin
      for (int t = 0; t < 2; t++) begin
        for (int l = 0; l < 16; l++) begin
          int n, tot;
          big = b[0];
          top_bottom_select = t[0];
          tot = b ? 128 : 512;
          n = nblk(l, b[0]);
          lat = 4'(l);
          wsr({2'b00, l[3:0], 2'b00});
          wait_idle();
          chk(status_out, {2'b00, l[3:0], 2'b00});
          if (n > 0) prog(t ? n - 1 : tot - n, 1, ARRAY_OPCODES[l % 13]);
          if (n < tot) prog(t ? n : tot - n - 1, 0, ARRAY_OPCODES[(l + 3) % 13]);
          cmd(8'h06, '0, '0);
          cmd(l[0] ? 8'hC7 : 8'h60, '0, '0);
          chk(arr_start, l == 0);
          chk(ignored, l != 0);
          if (l == 0) wait_idle();
          else cmd(8'h04, '0, '0);
        end
      end
    end
    for (int i = 0; i < 2; i++) begin
      cmd(i ? 8'h17 : 8'hC0, '0, '0);
      chk(vol, 1);
      chk(vol_op, i ? 8'h17 : 8'hC0);
    end
    cmd(8'h01, '0, 8'h00);
    chk(ignored, 1);
    lat = 4'h8;
    wsr(8'h80);
    cmd(8'hC0, '0, '0);
    chk(vol, 0);
    wait_idle();
    cmd(8'h06, '0, '0);
    cmd(8'h01, '0, 8'h00);
    chk(nv_write, 0);
    chk(locked, 1);
    cmd(8'h04, '0, '0);
    wp_n = 1'b1;
    hold_n = 1'b0;
    @(posedge mclk_in) #1;
    chk(locked, 0);
    chk(hold_on, 1);
    wsr(8'h40);
    wait_idle();
    cmd(8'h04, '0, '0);
    chk({quad, wp_fn, hold_fn, hold_on}, 4'h8);
    wsr(8'h00);
    wait_idle();
    cmd(8'h04, '0, '0);
    chk({quad, wp_fn, hold_fn, hold_on}, 4'h7);
    hold_n = 1'b1;
    wsr(8'h44);
    wait_idle();
    rst_in = 1'b1;
    repeat (2) @(posedge mclk_in);
    #1 rst_in = 1'b0;
    @(posedge mclk_in) #1;
    chk(status_out, 8'h44);
    end_of_test();
  end
endmodule
bind flash_block_write_protect flash_protect_sva u_sva (.mclk_in(mclk_in), .rst_in(rst_in),
  .cmd_valid_in(cmd_valid_in), .cmd_opcode_in(cmd_opcode_in), .cmd_data_in(cmd_data_in),
  .write_protect_n_in(write_protect_n_in), .nv_status_in(nv_status_in), .status_out(status_out),
  .array_start_out(array_start_out), .op_inhibited_out(op_inhibited_out), .cmd_ignored_out(cmd_ignored_out),
  .volatile_cmd_out(volatile_cmd_out), .volatile_opcode_out(volatile_opcode_out), .nv_write_out(nv_write_out),
  .nv_status_out(nv_status_out), .quad_enable_out(quad_enable_out), .wp_function_out(wp_function_out),
  .hold_function_out(hold_function_out));
`default_nettype wire
